// ==== hdl/sfra_pkg.sv ====
// Notes on behaviour
// RULE1: the eight 64-bit packed-integer registers sit in the same storage as the float stack, so a write through either view is seen by the other.
// RULE2: any packed-integer register reference marks every tag entry valid; an empty-state operation in the same cycle wins here and clears them.
// RULE3: the empty-state operation clears every tag entry, leaving the float stack empty.
// RULE4: the 128-bit vector registers are separate storage and need no empty-state operation around them.
// RULE5: a 128-bit vector memory reference off a 16-byte boundary raises a fault unless it is the unaligned wide move.
// RULE6: a 64-bit packed-integer memory reference off an 8-byte boundary completes without fault and may split across two cache lines.
// RULE7: a float push while all tag entries are still valid after packed-integer use raises a stack overflow fault.
// RULE8: software should issue the empty-state operation at the end of each packed-integer segment before float code.
// RULE9: vector operations on mismatched data types give the same result everywhere, only slower.
// RULE10: nearly all vector operations complete at one per cycle over three issue ports.
// RULE11: the tag word keeps one valid bit per stack register, eight in all, updated in a single step.
package sfra_pkg;
  localparam int SFRA_NREGS      = 8;
  localparam int SFRA_IDXW       = 3;
  localparam int SFRA_SHARED_W   = 64;
  localparam int SFRA_VEC_W      = 128;
  localparam int SFRA_NVEC       = 8;
  localparam int SFRA_VIDXW      = 3;
  localparam int SFRA_NPORTS     = 3;
  localparam int SFRA_ADDRW      = 32;
  localparam int SFRA_LINE_BYTES = 64;
  localparam int SFRA_WIDE_ALIGN = 16;
  localparam int SFRA_NARR_ALIGN = 8;
  localparam int SFRA_NARR_BYTES = 8;
  localparam logic [7:0] SFRA_TAG_ALL   = 8'hff;
  localparam logic [7:0] SFRA_TAG_EMPTY = 8'h00;
endpackage

// ==== hdl/sfra_regfile.sv ====
`timescale 1ns/1ps
module sfra_regfile
  import sfra_pkg::*;
#(
  parameter int NREGS  = SFRA_NREGS,
  parameter int NPORTS = SFRA_NPORTS
) (
  input  wire logic                     CLK_I,
  input  wire logic                     RST_N_I,
  // shared-file write, packed-integer view
  input  wire logic                     PI_WE_I,
  input  wire logic [SFRA_IDXW-1:0]     PI_WIDX_I,
  input  wire logic [SFRA_SHARED_W-1:0] PI_WDATA_I,
  // any packed-integer register reference
  input  wire logic                     PI_REF_I,
  // shared-file write, float stack view (physical index)
  input  wire logic                     FP_WE_I,
  input  wire logic [SFRA_IDXW-1:0]     FP_WIDX_I,
  input  wire logic [SFRA_SHARED_W-1:0] FP_WDATA_I,
  input  wire logic                     FP_PUSH_I,
  input  wire logic                     FP_POP_I,
  // empty-state operation
  input  wire logic                     EMPTY_OP_I,
  // shared read port
  input  wire logic [SFRA_IDXW-1:0]     RIDX_I,
  output logic      [SFRA_SHARED_W-1:0] RDATA_O,
  // vector file, one write and read per issue port
  input  wire logic [NPORTS-1:0]        VEC_WE_I,
  input  wire logic [NPORTS*SFRA_VIDXW-1:0] VEC_WIDX_I,
  input  wire logic [NPORTS*SFRA_VEC_W-1:0] VEC_WDATA_I,
  input  wire logic [NPORTS*SFRA_VIDXW-1:0] VEC_RIDX_I,
  output logic      [NPORTS*SFRA_VEC_W-1:0] VEC_RDATA_O,
  // memory reference alignment check
  input  wire logic                     MEM_VALID_I,
  input  wire logic                     MEM_WIDE_I,
  input  wire logic                     MEM_UNALIGNED_MOVE_I,
  input  wire logic [SFRA_ADDRW-1:0]    MEM_ADDR_I,
  output logic                          ALIGN_FAULT_O,
  output logic                          LINE_SPLIT_O,
  // tag word and stack overflow
  output logic      [NREGS-1:0]         TAG_VALID_O,
  output logic      [SFRA_IDXW-1:0]     TOP_O,
  output logic                          STACK_OVF_O
);

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [SFRA_SHARED_W-1:0] shared_mem [NREGS];
  logic [SFRA_VEC_W-1:0]    vec_mem [SFRA_NVEC];
  logic [NREGS-1:0]         tag_r;
  logic [NREGS-1:0]         tag_nxt;
  logic [SFRA_IDXW-1:0]     top_r;
  logic [SFRA_IDXW-1:0]     top_nxt;
  logic                     fault_r;
  logic                     split_r;
  logic                     ovf_r;
  logic [SFRA_SHARED_W-1:0] rdata_r;

  // misaligned test against a power-of-two boundary
  function automatic logic off_bound(input logic [SFRA_ADDRW-1:0] a,
                                     input int unsigned align);
    off_bound = (a & (SFRA_ADDRW'(align) - 1'b1)) != '0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // alignment decode
  wire logic [SFRA_ADDRW-1:0] last_byte =
    MEM_ADDR_I + SFRA_ADDRW'(SFRA_NARR_BYTES - 1);

  // address off its natural boundary, per access width
  wire logic wide_off   = off_bound(MEM_ADDR_I, SFRA_WIDE_ALIGN);
  wire logic narr_off   = off_bound(MEM_ADDR_I, SFRA_NARR_ALIGN);

  // first and last byte fall in different cache lines
  wire logic line_cross =
    (MEM_ADDR_I ^ last_byte) >= SFRA_ADDRW'(SFRA_LINE_BYTES);

  // wide reference off boundary faults unless it is the unaligned move
  wire logic wide_fault = MEM_VALID_I && MEM_WIDE_I && !MEM_UNALIGNED_MOVE_I
                          && wide_off; // RULE5

  // narrow reference never faults, only reports a line split
  wire logic narrow_split = MEM_VALID_I && !MEM_WIDE_I
                            && narr_off && line_cross; // RULE6

  ////////////////////////////////////////////////////////////////////////////
  // stack push with every entry still marked valid; empty and fill win
  wire logic push_ovf = FP_PUSH_I && !EMPTY_OP_I && !PI_REF_I
                        && (tag_r == SFRA_TAG_ALL); // RULE7

  // a refused push leaves tag and top alone, a pop with it included
  wire logic push_ok = FP_PUSH_I && !push_ovf;
  wire logic pop_ok  = FP_POP_I && !push_ovf;

  // neighbouring stack slots around the current top
  wire logic [SFRA_IDXW-1:0] push_slot = top_r - 1'b1;
  wire logic [SFRA_IDXW-1:0] pop_next  = top_r + 1'b1;

  // one-hot select of the entry that a push or a pop touches
  function automatic logic [NREGS-1:0] slot_sel(
    input logic [SFRA_IDXW-1:0] idx);
    slot_sel      = '0;
    slot_sel[idx] = 1'b1;
  endfunction

  wire logic [NREGS-1:0] pop_sel  = slot_sel(top_r);
  wire logic [NREGS-1:0] push_sel = slot_sel(push_slot);

  ////////////////////////////////////////////////////////////////////////////
  // tag word next value, every entry decided in the same step
  genvar t;
  generate
    for (t = 0; t < NREGS; t++) begin : g_tag
      // push and pop never select the same entry
      assign tag_nxt[t] =
        EMPTY_OP_I            ? SFRA_TAG_EMPTY[t] :   // RULE3 RULE11
        PI_REF_I              ? SFRA_TAG_ALL[t]   :   // RULE2 RULE11
        (push_ok && push_sel[t]) ? 1'b1 :
        (pop_ok && pop_sel[t])   ? 1'b0 :
        tag_r[t];
    end
  endgenerate

  // stack top next value; the fill resets it, empty leaves it
  always_comb begin
    top_nxt = top_r;
    if (PI_REF_I) begin
      top_nxt = '0;
    end else if (push_ok) begin
      top_nxt = push_slot;
    end else if (pop_ok) begin
      top_nxt = pop_next;
    end
  end

  // tag, top and status flags
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tag_r   <= SFRA_TAG_EMPTY;
      top_r   <= '0;
      fault_r <= 1'b0;
      split_r <= 1'b0;
      ovf_r   <= 1'b0;
    end else begin
      tag_r   <= tag_nxt;
      top_r   <= top_nxt;
      fault_r <= wide_fault;
      split_r <= narrow_split;
      ovf_r   <= push_ovf;
    end
  end

  // shared storage, both views write one array
  always_ff @(posedge CLK_I) begin
    if (FP_WE_I) begin
      shared_mem[FP_WIDX_I] <= FP_WDATA_I; // RULE1
    end
    if (PI_WE_I) begin
      shared_mem[PI_WIDX_I] <= PI_WDATA_I; // RULE1
    end
  end

  // registered shared read
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= shared_mem[RIDX_I];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector file, separate from the tag word, one op per port per cycle
  logic [SFRA_VIDXW-1:0] vwidx  [NPORTS];
  logic [SFRA_VEC_W-1:0] vwdata [NPORTS];
  logic [SFRA_VIDXW-1:0] vridx  [NPORTS];

  // per-port slices of the flat port buses
  genvar p;
  generate
    for (p = 0; p < NPORTS; p++) begin : g_slice
      assign vwidx[p]  = VEC_WIDX_I[p*SFRA_VIDXW +: SFRA_VIDXW];
      assign vwdata[p] = VEC_WDATA_I[p*SFRA_VEC_W +: SFRA_VEC_W];
      assign vridx[p]  = VEC_RIDX_I[p*SFRA_VIDXW +: SFRA_VIDXW];
    end
  endgenerate

  // all port writes in one process; a later port wins an index tie
  always_ff @(posedge CLK_I) begin
    for (int w = 0; w < NPORTS; w++) begin
      if (VEC_WE_I[w]) begin
        vec_mem[vwidx[w]] <= vwdata[w]; // RULE4 RULE10
      end
    end
  end

  // registered read per port
  generate
    for (p = 0; p < NPORTS; p++) begin : g_port
      logic [SFRA_VEC_W-1:0] vrd_r;
      always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
          vrd_r <= '0;
        end else begin
          // raw bits, no type check on contents
          vrd_r <= vec_mem[vridx[p]]; // RULE9 RULE10
        end
      end
      assign VEC_RDATA_O[p*SFRA_VEC_W +: SFRA_VEC_W] = vrd_r;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA_O       = rdata_r;
  assign TAG_VALID_O   = tag_r;
  assign TOP_O         = top_r;
  assign ALIGN_FAULT_O = fault_r;
  assign LINE_SPLIT_O  = split_r;
  assign STACK_OVF_O   = ovf_r;

endmodule // sfra_regfile

// ==== dv/sfra_regfile_asserts.sv ====
`timescale 1ns/1ps
module sfra_regfile_asserts (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        PI_REF_I,
  input wire logic        EMPTY_OP_I,
  input wire logic        FP_PUSH_I,
  input wire logic        FP_POP_I,
  input wire logic        MEM_VALID_I,
  input wire logic        MEM_WIDE_I,
  input wire logic        MEM_UNALIGNED_MOVE_I,
  input wire logic [31:0] MEM_ADDR_I,
  input wire logic        ALIGN_FAULT_O,
  input wire logic [7:0]  TAG_VALID_O,
  input wire logic [2:0]  TOP_O,
  input wire logic        STACK_OVF_O
);
  // causes of a wide fault and of an overflow
  wire bad = MEM_VALID_I & MEM_WIDE_I & !MEM_UNALIGNED_MOVE_I
             & (MEM_ADDR_I[3:0] != 4'h0);
  wire ovf = FP_PUSH_I & !EMPTY_OP_I & !PI_REF_I & (TAG_VALID_O == 8'hff);
  wire idle = !PI_REF_I & !EMPTY_OP_I & !FP_PUSH_I & !FP_POP_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_ref_fill: assert property (PI_REF_I && !EMPTY_OP_I |=>
    TAG_VALID_O == 8'hff && TOP_O == 3'h0) else $error("tag not filled");
  chk_empty_clear: assert property (EMPTY_OP_I |=>
    TAG_VALID_O == 8'h00) else $error("tag not cleared");
  chk_wide_fault: assert property (bad |=> ALIGN_FAULT_O)
    else $error("missing align fault");
  chk_fault_cause: assert property (ALIGN_FAULT_O |-> $past(bad))
    else $error("spurious align fault");
  chk_ovf_raise: assert property (ovf |=> STACK_OVF_O)
    else $error("missing overflow");
  chk_ovf_cause: assert property (STACK_OVF_O |-> $past(ovf))
    else $error("spurious overflow");
  chk_ovf_keep: assert property (ovf |=> $stable(TAG_VALID_O))
    else $error("tag changed on overflow");
  chk_tag_idle: assert property (idle |=> $stable(TAG_VALID_O))
    else $error("tag changed while idle");
endmodule // sfra_regfile_asserts
bind sfra_regfile sfra_regfile_asserts u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .PI_REF_I(PI_REF_I), .EMPTY_OP_I(EMPTY_OP_I), .FP_PUSH_I(FP_PUSH_I),
  .FP_POP_I(FP_POP_I), .MEM_VALID_I(MEM_VALID_I), .MEM_WIDE_I(MEM_WIDE_I),
  .MEM_UNALIGNED_MOVE_I(MEM_UNALIGNED_MOVE_I), .MEM_ADDR_I(MEM_ADDR_I),
  .ALIGN_FAULT_O(ALIGN_FAULT_O), .TAG_VALID_O(TAG_VALID_O), .TOP_O(TOP_O),
  .STACK_OVF_O(STACK_OVF_O));

// ==== dv/sfra_regfile_bench.sv ====
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module sfra_regfile_bench;
  import sfra_pkg::*;
  logic CLK_I, RST_N_I, PI_WE_I, PI_REF_I, FP_WE_I, FP_PUSH_I, FP_POP_I;
  logic EMPTY_OP_I, MEM_VALID_I, MEM_WIDE_I, MEM_UNALIGNED_MOVE_I;
  logic ALIGN_FAULT_O, LINE_SPLIT_O, STACK_OVF_O;
  logic [2:0] PI_WIDX_I, FP_WIDX_I, RIDX_I, TOP_O, VEC_WE_I;
  logic [63:0] PI_WDATA_I, FP_WDATA_I, RDATA_O;
  logic [8:0] VEC_WIDX_I, VEC_RIDX_I;
  logic [383:0] VEC_WDATA_I, VEC_RDATA_O;
  logic [31:0] MEM_ADDR_I;
  logic [7:0] TAG_VALID_O;
  int err_total = 0, checks_done = 0;
  sfra_regfile dut (.CLK_I, .RST_N_I, .PI_WE_I, .PI_WIDX_I, .PI_WDATA_I,
    .PI_REF_I, .FP_WE_I, .FP_WIDX_I, .FP_WDATA_I, .FP_PUSH_I, .FP_POP_I,
    .EMPTY_OP_I, .RIDX_I, .RDATA_O, .VEC_WE_I, .VEC_WIDX_I, .VEC_WDATA_I,
    .VEC_RIDX_I, .VEC_RDATA_O, .MEM_VALID_I, .MEM_WIDE_I,
    .MEM_UNALIGNED_MOVE_I, .MEM_ADDR_I, .ALIGN_FAULT_O, .LINE_SPLIT_O,
    .TAG_VALID_O, .TOP_O, .STACK_OVF_O);
  initial begin
    CLK_I = 0;
    forever #12.5 CLK_I = ~CLK_I;
  end
  task step; @(posedge CLK_I); #1; endtask
  task clr; {PI_WE_I, PI_REF_I, FP_WE_I, FP_PUSH_I, FP_POP_I, EMPTY_OP_I,
    VEC_WE_I} = '0; endtask
  // one memory reference, then fault and split flags
  task mem(input logic w, u, input logic [31:0] a, input logic f, s);
    MEM_VALID_I = 1; MEM_WIDE_I = w; MEM_UNALIGNED_MOVE_I = u; MEM_ADDR_I = a;
    step;
    `CHK({ALIGN_FAULT_O, LINE_SPLIT_O}, {f, s})
  endtask
  task t_alias;
    PI_WE_I = 1; PI_WIDX_I = 3'h3; PI_WDATA_I = 64'h1122334455667788;
    step; clr; RIDX_I = 3'h3; step;
    `CHK(RDATA_O, 64'h1122334455667788)
    FP_WE_I = 1; FP_WIDX_I = 3'h3; FP_WDATA_I = 64'h0f0e0d0c0b0a0908;
    step; clr; step;
    `CHK(RDATA_O, 64'h0f0e0d0c0b0a0908)
  endtask
  task t_tag;
    PI_REF_I = 1; step; clr;
    `CHK({TAG_VALID_O, TOP_O}, {SFRA_TAG_ALL, 3'h0})
    EMPTY_OP_I = 1; PI_REF_I = 1; step; clr;
    `CHK(TAG_VALID_O, SFRA_TAG_EMPTY)
  endtask
  task t_ovf;
    PI_REF_I = 1; step; PI_REF_I = 0; FP_PUSH_I = 1; step; clr;
    `CHK({STACK_OVF_O, TAG_VALID_O}, {1'b1, SFRA_TAG_ALL})
    EMPTY_OP_I = 1; step; clr;
    FP_PUSH_I = 1; step; clr;
    `CHK(STACK_OVF_O, 1'b0)
    `CHK({TAG_VALID_O, TOP_O}, {8'h80, 3'h7})
    FP_POP_I = 1; step; clr;
    `CHK({TAG_VALID_O, TOP_O}, {8'h00, 3'h0})
  endtask
  task t_vec;
    VEC_WE_I = 3'h5; VEC_WIDX_I = 9'h142; VEC_WDATA_I[127:0] = 128'h5a5a00ff;
    VEC_WDATA_I[383:256] = 128'hc3c3;
    step; clr; PI_WE_I = 1; PI_WIDX_I = 3'h2; EMPTY_OP_I = 1;
    VEC_RIDX_I = 9'h142; step; clr; step;
    `CHK(VEC_RDATA_O[127:0], 128'h5a5a00ff)
    `CHK(VEC_RDATA_O[383:256], 128'hc3c3)
  endtask
  task t_align;
    mem(1, 0, 32'h4, 1, 0);
    mem(1, 0, 32'h10, 0, 0);
    mem(1, 1, 32'h4, 0, 0);
    mem(0, 0, 32'h3c, 0, 1);
    mem(0, 0, 32'h3, 0, 0);
    MEM_VALID_I = 0;
  endtask
  task results;
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    RST_N_I = 0; clr; MEM_VALID_I = 0; MEM_WIDE_I = 0; RIDX_I = 0;
    {PI_WIDX_I, PI_WDATA_I, FP_WIDX_I, FP_WDATA_I, VEC_WIDX_I} = '0;
    {VEC_WDATA_I, VEC_RIDX_I, MEM_UNALIGNED_MOVE_I, MEM_ADDR_I} = '0;
    repeat (4) @(posedge CLK_I);
    #1 RST_N_I = 1;
    t_alias; t_tag; t_ovf; t_vec; t_align;
    results;
  end
  initial begin
    #20us err_total++;
    results;
  end
endmodule // sfra_regfile_bench
